// [verilog/psid_top.sv]
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
// Skip instruction decoder and executor of the capture DMA sequencer
module psid_top (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        NRST,
    // Register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [31:0]      RDATA,
    // Instruction fetch
    input  wire logic        INSN_VALID,
    input  wire logic [31:0] INSN_DATA,
    output logic             INSN_READY,
    // Pixel FIFOs: bit 0 luma, 1 chroma A, 2 chroma B
    input  wire logic [2:0]  FIFO_VALID,
    input  wire logic        FIFO_EOL,
    output logic [2:0]       FIFO_POP,
    // Sequencer state
    output logic [3:0]       SEQ_STATUS,
    output logic [31:0]      TARGET_ADDR,
    output logic             BUSY,
    output logic             IRQ
);

    localparam int P  = psid_pkg::PLANES;
    localparam int CW = psid_pkg::CNT_W;

    psid_pkg::psid_state_e state_reg;
    psid_pkg::psid_state_e state_next;
    logic [31:0]             dw0_reg;
    logic [31:0]             dw0_next;
    logic                    swallow_reg;
    logic                    swallow_next;
    logic                    fl_end_reg;
    logic                    fl_end_next;
    logic                    ready_reg;
    logic                    ready_next;
    logic                    busy_reg;
    logic                    busy_next;
    logic                    en_reg;
    logic                    en_next;
    logic [3:0]              stat_reg;
    logic [3:0]              stat_next;
    logic [1:0]              ist_reg;
    logic [1:0]              ist_next;
    logic [1:0]              ien_reg;
    logic [1:0]              ien_next;
    logic                    irq_reg;
    logic                    irq_next;
    logic [31:0]             tgt_reg;
    logic [31:0]             tgt_next;
    logic [31:0]             rdata_reg;
    logic [31:0]             rdata_next;
    logic [P-1:0]            start;
    logic                    abort;
    logic [CW-1:0]           cnt     [P];
    logic                    load_lane;
    logic [P-1:0]            sk_busy;
    logic [1:0]              sk_lane [P];
    logic [2:0]              sk_used [P];
    logic [1:0]              ist_set;
    logic                    complete;
    logic                    got;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] opcode(input logic [31:0] dw);
        opcode = dw[psid_pkg::OPC_HI:psid_pkg::OPC_LO];
    endfunction : opcode

    function automatic logic is_skip(input logic [31:0] dw);
        is_skip = (opcode(dw) == psid_pkg::OP_PACKED_SKIP) ||
                  (opcode(dw) == psid_pkg::OP_PLANAR_SKIP);
    endfunction : is_skip

    // ------------------------------------------------------------
    // Byte discarders, one per plane
    // ------------------------------------------------------------
    for (genvar g = 0; g < P; g++)
    begin : g_plane
        psid_skipper #(.CNT_W(CW)) u_skip (
            .clk        (CLK),
            .nrst       (NRST),
            .start      (start[g]),
            .abort      (abort),
            .count      (cnt[g]),
            .load_lane  (load_lane),
            .lane_in    (INSN_DATA[psid_pkg::OFS_HI:psid_pkg::OFS_LO]),
            .fifo_valid (FIFO_VALID[g]),
            .pop        (FIFO_POP[g]),
            .busy       (sk_busy[g]),
            .lane       (sk_lane[g]),
            .consumed   (sk_used[g])
        );
    end

    // ------------------------------------------------------------
    // Sequencer, status, interrupts and register port
    // ------------------------------------------------------------
    // A word is taken only while ready already stands
    always_comb
    begin
        state_next   = state_reg;
        dw0_next     = dw0_reg;
        swallow_next = swallow_reg;
        fl_end_next  = fl_end_reg;
        en_next      = en_reg;
        stat_next    = stat_reg;
        ien_next     = ien_reg;
        start        = '0;
        abort        = 1'b0;
        load_lane    = 1'b0;
        complete     = 1'b0;
        ist_set      = '0;
        got          = INSN_VALID && ready_reg;
        for (int i = 0; i < P; i++)
            cnt[i] = '0;
        case (state_reg)
            psid_pkg::ST_IDLE:
            begin
                if (got && is_skip(INSN_DATA))
                begin
                    dw0_next = INSN_DATA;
                    if (opcode(INSN_DATA) == psid_pkg::OP_PLANAR_SKIP)
                        state_next = psid_pkg::ST_FETCH; // Second DWORD follows
                    else
                    begin
                        cnt[0]     = INSN_DATA[psid_pkg::CNT_HI:psid_pkg::CNT_LO];
                        start[0]   = 1'b1;
                        load_lane  = INSN_DATA[psid_pkg::OFS_HI:psid_pkg::OFS_LO] != 2'h0;
                        state_next = psid_pkg::ST_RUN;
                    end
                end
            end
            psid_pkg::ST_FETCH:
            begin
                if (got)
                begin
                    cnt[0]     = dw0_reg[psid_pkg::CNT_HI:psid_pkg::CNT_LO];
                    cnt[1]     = INSN_DATA[psid_pkg::CNT_HI:psid_pkg::CNT_LO];
                    cnt[2]     = INSN_DATA[psid_pkg::CNT3_HI:psid_pkg::CNT3_LO];
                    start      = '1;
                    state_next = psid_pkg::ST_RUN;
                end
            end
            psid_pkg::ST_RUN:
            begin
                if (FIFO_EOL)
                begin
                    abort = 1'b1;
                    if (dw0_reg[psid_pkg::LINE_LAST])
                    begin
                        complete   = 1'b1; // Line ends on this very instruction
                        state_next = psid_pkg::ST_IDLE;
                    end
                    else
                    begin
                        ist_set[psid_pkg::INT_ABORT] = 1'b1;
                        swallow_next = 1'b0;
                        fl_end_next  = 1'b0;
                        state_next   = psid_pkg::ST_FLUSH;
                    end
                end
                else if (sk_busy == '0)
                begin
                    complete   = 1'b1;
                    state_next = psid_pkg::ST_IDLE;
                end
            end
            psid_pkg::ST_FLUSH:
            begin
                // Skips up to the line-last one are dropped unexecuted
                if (got && swallow_reg)
                begin
                    swallow_next = 1'b0;
                    if (fl_end_reg)
                        state_next = psid_pkg::ST_IDLE;
                end
                else if (got && is_skip(INSN_DATA))
                begin
                    swallow_next = opcode(INSN_DATA) == psid_pkg::OP_PLANAR_SKIP;
                    fl_end_next  = INSN_DATA[psid_pkg::LINE_LAST];
                    if (INSN_DATA[psid_pkg::LINE_LAST] &&
                        opcode(INSN_DATA) != psid_pkg::OP_PLANAR_SKIP)
                        state_next = psid_pkg::ST_IDLE;
                end
            end
            default:
                state_next = psid_pkg::ST_IDLE;
        endcase

        // Status reset then set mask, and completion interrupt
        if (complete)
        begin
            stat_next = (stat_reg & ~dw0_reg[psid_pkg::STAT_RST_HI:psid_pkg::STAT_RST_LO])
                        | dw0_reg[psid_pkg::STAT_SET_HI:psid_pkg::STAT_SET_LO];
            ist_set[psid_pkg::INT_DONE] = dw0_reg[psid_pkg::IRQ_REQ];
        end

        // Address keeps counting through skipped luma bytes
        tgt_next = tgt_reg + {29'h0000_0000, sk_used[0]};

        // Register writes; instruction status updates win over software
        if (WR)
        begin
            if (ADDR == psid_pkg::REG_CTRL)
                en_next = WDATA[psid_pkg::CTRL_EN];
            else if (ADDR == psid_pkg::REG_STATUS && !complete)
                stat_next = WDATA[psid_pkg::STAT_W-1:0];
            else if (ADDR == psid_pkg::REG_INT_EN)
                ien_next = WDATA[psid_pkg::INT_W-1:0];
            else if (ADDR == psid_pkg::REG_TARGET)
                tgt_next = WDATA;
        end

        // Sticky events: a set in the clearing cycle survives
        if (WR && ADDR == psid_pkg::REG_INT_CLR)
            ist_next = (ist_reg & ~WDATA[psid_pkg::INT_W-1:0]) | ist_set;
        else
            ist_next = ist_reg | ist_set;
        irq_next = |(ist_next & ien_next);

        // Read data appear only in the cycle after the strobe
        rdata_next = 32'h0000_0000;
        if (RD)
        begin
            if (ADDR == psid_pkg::REG_CTRL)
                rdata_next = {31'h0000_0000, en_reg};
            else if (ADDR == psid_pkg::REG_STATUS)
                rdata_next = {28'h000_0000, stat_reg};
            else if (ADDR == psid_pkg::REG_INT_STAT)
                rdata_next = {30'h0000_0000, ist_reg};
            else if (ADDR == psid_pkg::REG_INT_EN)
                rdata_next = {30'h0000_0000, ien_reg};
            else if (ADDR == psid_pkg::REG_TARGET)
                rdata_next = tgt_reg;
            else if (ADDR == psid_pkg::REG_LANES)
                rdata_next = {24'h00_0000, state_reg, sk_lane[2], sk_lane[1], sk_lane[0]};
        end

        // Ready only when the next state can take a word
        ready_next = en_next && (state_next != psid_pkg::ST_RUN);
        busy_next  = state_next != psid_pkg::ST_IDLE;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            state_reg   <= psid_pkg::ST_IDLE;
            dw0_reg     <= 32'h0000_0000;
            swallow_reg <= 1'b0;
            fl_end_reg  <= 1'b0;
            ready_reg   <= 1'b0;
            busy_reg    <= 1'b0;
            en_reg      <= 1'b0;
            stat_reg    <= 4'h0;
            ist_reg     <= 2'h0;
            ien_reg     <= 2'h0;
            irq_reg     <= 1'b0;
            tgt_reg     <= psid_pkg::TARGET_RST;
            rdata_reg   <= 32'h0000_0000;
        end
        else
        begin
            state_reg   <= state_next;
            dw0_reg     <= dw0_next;
            swallow_reg <= swallow_next;
            fl_end_reg  <= fl_end_next;
            ready_reg   <= ready_next;
            busy_reg    <= busy_next;
            en_reg      <= en_next;
            stat_reg    <= stat_next;
            ist_reg     <= ist_next;
            ien_reg     <= ien_next;
            irq_reg     <= irq_next;
            tgt_reg     <= tgt_next;
            rdata_reg   <= rdata_next;
        end
    end

    assign RDATA       = rdata_reg;
    assign INSN_READY  = ready_reg;
    assign SEQ_STATUS  = stat_reg;
    assign TARGET_ADDR = tgt_reg;
    assign BUSY        = busy_reg;
    assign IRQ         = irq_reg;

endmodule : psid_top

// [verilog/psid_pkg.sv]
// Notes on behaviour
// - Opcode 0010 in the top nibble is the one-DWORD packed skip.
// - Packed skip: byte count from bits 11:0, start byte lane from bits 13:12 when nonzero; 00 keeps the current lane.
// - Skips may start and end on any lane; leftover bytes stay for the next one.
// - Opcode 1010 is the two-DWORD planar skip; luma count from bits 11:0.
// - Second DWORD: chroma A count bits 11:0, chroma B count bits 27:16.
// - Early FIFO end of line aborts everything up to the line-last instruction.
// - The target address counter keeps advancing while luma bytes are skipped.
package psid_pkg;

    // ------------------------------------------------------------
    // Instruction fields
    // ------------------------------------------------------------
    localparam logic [3:0] OP_PACKED_SKIP = 4'h2;
    localparam logic [3:0] OP_PLANAR_SKIP = 4'hA;
    localparam int OPC_HI        = 31;
    localparam int OPC_LO        = 28;
    localparam int LINE_FIRST    = 27;
    localparam int LINE_LAST     = 26;
    localparam int IRQ_REQ       = 24;
    localparam int STAT_RST_HI   = 23;
    localparam int STAT_RST_LO   = 20;
    localparam int STAT_SET_HI   = 19;
    localparam int STAT_SET_LO   = 16;
    localparam int OFS_HI        = 13;
    localparam int OFS_LO        = 12;
    localparam int CNT_HI        = 11;
    localparam int CNT_LO        = 0;
    localparam int CNT3_HI       = 27;
    localparam int CNT3_LO       = 16;
    localparam int CNT_W         = 12;
    localparam int LANE_W        = 2;
    localparam int STAT_W        = 4;
    localparam int PLANES        = 3;
    localparam logic [2:0] BYTES_PER_WORD = 3'h4;

    // ------------------------------------------------------------
    // Register map (byte addresses) and interrupt bits
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_INT_STAT = 8'h08;
    localparam logic [7:0] REG_INT_EN   = 8'h0C;
    localparam logic [7:0] REG_INT_CLR  = 8'h10;
    localparam logic [7:0] REG_TARGET   = 8'h14;
    localparam logic [7:0] REG_LANES    = 8'h18;
    localparam int INT_W     = 2;
    localparam int INT_DONE  = 0;
    localparam int INT_ABORT = 1;
    localparam int CTRL_EN   = 0;
    localparam logic [31:0] TARGET_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_RUN   = 2'b10,
        ST_FLUSH = 2'b11
    } psid_state_e;

endpackage : psid_pkg

// [verilog/psid_skipper.sv]
`timescale 1ns/1ps
// Byte discarder for one pixel FIFO; the lane survives between instructions
module psid_skipper #(
    parameter int CNT_W = 12
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Control from the sequencer
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic [CNT_W-1:0] count,
    input  wire logic             load_lane,
    input  wire logic [1:0]       lane_in,
    // FIFO side
    input  wire logic             fifo_valid,
    output logic                  pop,
    // Status
    output logic                  busy,
    output logic [1:0]            lane,
    output logic [2:0]            consumed
);

    logic [CNT_W-1:0] remain_reg;
    logic [CNT_W-1:0] remain_next;
    logic [1:0]       lane_reg;
    logic [1:0]       lane_next;
    logic             pop_reg;
    logic             pop_next;
    logic             busy_reg;
    logic             busy_next;
    logic [2:0]       avail;
    logic [2:0]       take;
    logic [2:0]       lane_sum;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // No byte is taken in the cycle a pop is out: the FIFO word is stale then
    always_comb
    begin
        remain_next = remain_reg;
        lane_next   = lane_reg;
        pop_next    = 1'b0;
        busy_next   = busy_reg;
        avail       = psid_pkg::BYTES_PER_WORD - {1'b0, lane_reg};
        take        = 3'h0;
        lane_sum    = {1'b0, lane_reg};
        if (abort)
        begin
            busy_next   = 1'b0;
            remain_next = '0;
            lane_next   = 2'h0;
            pop_next    = (lane_reg != 2'h0) && !pop_reg; // Drop the partial word
        end
        else if (start)
        begin
            busy_next   = 1'b1;
            remain_next = count;
            if (load_lane)
                lane_next = lane_in;
        end
        else if (busy_reg)
        begin
            if (remain_reg == '0)
                busy_next = 1'b0;
            else if (fifo_valid && !pop_reg)
            begin
                // Take at most what is left in this word
                if ({{(CNT_W-3){1'b0}}, avail} > remain_reg)
                    take = remain_reg[2:0];
                else
                    take = avail;
                remain_next = remain_reg - {{(CNT_W-3){1'b0}}, take};
                lane_sum    = {1'b0, lane_reg} + take;
                lane_next   = lane_sum[1:0];
                pop_next    = lane_sum[2]; // Word fully used, free it
            end
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            remain_reg <= '0;
            lane_reg   <= 2'h0;
            pop_reg    <= 1'b0;
            busy_reg   <= 1'b0;
        end
        else
        begin
            remain_reg <= remain_next;
            lane_reg   <= lane_next;
            pop_reg    <= pop_next;
            busy_reg   <= busy_next;
        end
    end

    assign pop      = pop_reg;
    assign busy     = busy_reg;
    assign lane     = lane_reg;
    assign consumed = take;

endmodule : psid_skipper

// [verif/psid_top_assertions.sv]
`timescale 1ns/1ps
// Port-level checks of the skip sequencer
module psid_top_assertions (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        NRST,
    // Register port
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    // Fetch and pixel side
    input wire logic        INSN_VALID,
    input wire logic [31:0] INSN_DATA,
    input wire logic        INSN_READY,
    input wire logic [2:0]  FIFO_POP,
    input wire logic [31:0] TARGET_ADDR,
    input wire logic        BUSY,
    input wire logic        IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    // ------------------------------------------------------------
    // Fetch steps
    // ------------------------------------------------------------
    sequence s_take(logic [3:0] op);
        !BUSY && INSN_VALID && INSN_READY && INSN_DATA[31:28] == op;
    endsequence
    sequence s_second;
        INSN_VALID && INSN_READY;
    endsequence
    property p_packed_take;
        s_take(psid_pkg::OP_PACKED_SKIP) |=> BUSY && !INSN_READY;
    endproperty
    a_packed_take: assert property (p_packed_take) else $error("packed skip not started");
    property p_planar_wait;
        s_take(psid_pkg::OP_PLANAR_SKIP) |=> BUSY && INSN_READY;
    endproperty
    a_planar_wait: assert property (p_planar_wait) else $error("planar second word not awaited");
    property p_planar_run;
        s_take(psid_pkg::OP_PLANAR_SKIP) ##1 s_second |=> BUSY && !INSN_READY;
    endproperty
    a_planar_run: assert property (p_planar_run) else $error("planar skip not started");
    property p_other_op;
        !BUSY && INSN_VALID && INSN_READY && INSN_DATA[31:28] != psid_pkg::OP_PACKED_SKIP
            && INSN_DATA[31:28] != psid_pkg::OP_PLANAR_SKIP |=> !BUSY;
    endproperty
    a_other_op: assert property (p_other_op) else $error("foreign opcode started a skip");
    // ------------------------------------------------------------
    // Pixel and bus side
    // ------------------------------------------------------------
    // Pop is a pulse, so the FIFO has a cycle to advance
    property p_pop_gap;
        (FIFO_POP & $past(FIFO_POP)) == 3'h0;
    endproperty
    a_pop_gap: assert property (p_pop_gap) else $error("pop repeated");
    property p_pop_busy;
        FIFO_POP != 3'h0 |-> $past(BUSY);
    endproperty
    a_pop_busy: assert property (p_pop_busy) else $error("pop while idle");
    property p_target_move;
        TARGET_ADDR != $past(TARGET_ADDR) |-> $past(BUSY) || $past(WR);
    endproperty
    a_target_move: assert property (p_target_move) else $error("target moved idle");
    property p_rdata_quiet;
        !$past(RD) |-> RDATA == 32'h0000_0000;
    endproperty
    a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside slot");
    property p_irq_cause;
        $rose(IRQ) |-> $past(BUSY) || $past(WR) || $past(BUSY, 2) || $past(WR, 2);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
endmodule : psid_top_assertions

bind psid_top psid_top_assertions i_chk (.CLK(CLK), .NRST(NRST), .WR(WR), .RD(RD),
    .RDATA(RDATA), .INSN_VALID(INSN_VALID), .INSN_DATA(INSN_DATA), .INSN_READY(INSN_READY),
    .FIFO_POP(FIFO_POP), .TARGET_ADDR(TARGET_ADDR), .BUSY(BUSY), .IRQ(IRQ));

// [verif/psid_fifo_model.sv]
`timescale 1ns/1ps
// Three pixel FIFOs that always hold a word unless held back
module psid_fifo_model (
    // Clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    // Pacing from the bench
    input wire logic       stall,
    input wire logic       slow,
    // FIFO side
    input wire logic [2:0] pop,
    output logic [2:0]     valid,
    output int             n_pop [3]
);
    logic ph_reg;
    // Each pop advances one word and is counted
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ph_reg <= 1'b0;
            n_pop  <= '{0, 0, 0};
        end
        else
        begin
            ph_reg <= ~ph_reg;
            for (int i = 0; i < 3; i++)
                n_pop[i] <= n_pop[i] + int'(pop[i]);
        end
    end
    // Slow mode offers a word only every other cycle
    assign valid = {3{~stall & (~slow | ph_reg)}};
endmodule : psid_fifo_model

// [verif/tb_top.sv]
`timescale 1ns/1ps
// Self-checking bench of the skip sequencer
module tb_top;
    typedef struct {string nm; logic [31:0] v;} psid_exp_s;
    // Design ports and bench state
    logic        CLK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0, INSN_VALID = 1'b0;
    logic        FIFO_EOL = 1'b0, stall = 1'b0, slow = 1'b0, rd_d = 1'b0;
    logic [7:0]  ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0, INSN_DATA = 32'h0, RDATA, TARGET_ADDR, tgt, w;
    logic [2:0]  FIFO_VALID, FIFO_POP;
    logic [3:0]  SEQ_STATUS;
    logic        INSN_READY, BUSY, IRQ;
    logic [15:0] seed = 16'h0004;
    int          n_mismatch = 0, tests_run = 0, cyc = 0, n_pop [3];
    int          lane [3], pops [3];
    psid_exp_s   exp_q [$];
    psid_top i_psid_top (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .INSN_VALID(INSN_VALID), .INSN_DATA(INSN_DATA),
        .INSN_READY(INSN_READY), .FIFO_VALID(FIFO_VALID), .FIFO_EOL(FIFO_EOL),
        .FIFO_POP(FIFO_POP), .SEQ_STATUS(SEQ_STATUS), .TARGET_ADDR(TARGET_ADDR),
        .BUSY(BUSY), .IRQ(IRQ));
    psid_fifo_model i_psid_fifo_model (.clk(CLK), .nrst(NRST), .stall(stall), .slow(slow),
        .pop(FIFO_POP), .valid(FIFO_VALID), .n_pop(n_pop));
    always #25 CLK = ~CLK;
    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    // Strobes stay up between back-to-back calls
    task automatic bus(input logic w_en, input logic [7:0] a, input logic [31:0] d);
        WR <= w_en;
        RD <= ~w_en;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
    endtask : bus
    task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] e);
        exp_q.push_back('{nm, e});
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic quiet();
        WR <= 1'b0;
        RD <= 1'b0;
        @(posedge CLK);
    endtask : quiet
    task automatic send(input logic [31:0] d);
        INSN_VALID <= 1'b1;
        INSN_DATA <= d;
        @(negedge CLK);
        while (INSN_READY !== 1'b1)
            @(negedge CLK);
        @(posedge CLK);
    endtask : send
    // Released fetch data shows the inverse
    task automatic done();
        INSN_VALID <= 1'b0;
        INSN_DATA <= ~INSN_DATA;
        @(negedge CLK);
        while (BUSY !== 1'b0)
            @(negedge CLK);
        @(posedge CLK);
    endtask : done
    function automatic void eat(input int p, input int c);
        pops[p] += (lane[p] + c) / 4;
        lane[p] = (lane[p] + c) % 4;
        if (p == 0)
            tgt = tgt + 32'(c);
    endfunction : eat
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic verify();
        chk("target pin", tgt, TARGET_ADDR);
        for (int p = 0; p < 3; p++)
            chk("words", 32'(pops[p]), 32'(n_pop[p]));
        rd(psid_pkg::REG_TARGET, "target", tgt);
        rd(psid_pkg::REG_LANES, "lanes", {26'h0, 2'(lane[2]), 2'(lane[1]), 2'(lane[0])});
        quiet();
    endtask : verify
    // Read data stands only in the cycle after the strobe
    always @(posedge CLK)
        rd_d <= RD;
    always @(negedge CLK)
    begin : mon
        psid_exp_s e;
        if (rd_d && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            chk(e.nm, e.v, RDATA);
        end
    end
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge CLK);
        NRST <= 1'b1;
        @(posedge CLK);
        bus(1'b1, psid_pkg::REG_INT_STAT, 32'hFFFF_FFFF);
        for (int a = 0; a < 32; a += 4)
            rd(8'(a), "reset", 32'h0);
        bus(1'b1, psid_pkg::REG_CTRL, 32'h1);
        bus(1'b1, psid_pkg::REG_TARGET, 32'h100);
        bus(1'b1, psid_pkg::REG_INT_EN, 32'h1);
        quiet();
        tgt = 32'h100;
        $display("registers test done");
        stall <= 1'b1;
        send(32'h5000_0010);
        done();
        chk("busy", 1'b0, BUSY);
        send(32'h2000_0028);
        INSN_VALID <= 1'b0;
        FIFO_EOL <= 1'b1;
        @(posedge CLK);
        FIFO_EOL <= 1'b0;
        stall <= 1'b0;
        rd(psid_pkg::REG_INT_STAT, "abort", 32'h2);
        quiet();
        chk("masked irq", 1'b0, IRQ);
        bus(1'b1, psid_pkg::REG_INT_EN, 32'h3);
        quiet();
        chk("irq", 1'b1, IRQ);
        bus(1'b1, psid_pkg::REG_INT_CLR, 32'h2);
        quiet();
        chk("cleared irq", 1'b0, IRQ);
        send(32'h2000_0010); // reserved bits zero
        send(32'h2400_0004); // last of the line
        done();
        verify();
        $display("early line end test done");
        bus(1'b1, psid_pkg::REG_STATUS, 32'hA);
        quiet();
        send(32'h2105_1006);
        done();
        lane[0] = 1;
        eat(0, 6);
        chk("irq", 1'b1, IRQ);
        chk("status", 4'hF, SEQ_STATUS);
        verify();
        send(32'h2410_0001);
        done();
        eat(0, 1);
        chk("status", 4'hE, SEQ_STATUS);
        bus(1'b1, psid_pkg::REG_INT_CLR, 32'h1);
        rd(psid_pkg::REG_INT_STAT, "int", 32'h0);
        verify();
        $display("packed test done");
        repeat (16)
        begin
            seed = lfsr(seed);
            w = {seed, seed[7:0], ~seed[15:8]};
            slow <= w[31];
            if (w[30])
            begin
                send({4'hA, 20'h0, w[7:0]});
                send({8'h00, w[15:8], 8'h00, w[23:16]});
                eat(0, int'(w[7:0]));
                eat(1, int'(w[23:16]));
                eat(2, int'(w[15:8]));
            end
            else
            begin
                send({4'h2, 14'h0, w[13:12], 4'h0, w[7:0]});
                if (w[13:12] != 2'b00)
                    lane[0] = int'(w[13:12]);
                eat(0, int'(w[7:0]));
            end
            done();
            verify();
        end
        $display("random test done");
        wrap_up();
    end
endmodule : tb_top
